// *** rtl/ddc_pkg.sv ***
`default_nettype none
package ddc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [4:0] OFS_SRC = 5'h00;
  localparam logic [4:0] OFS_DST = 5'h04;
  localparam logic [4:0] OFS_CNT = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0c;
  localparam logic [4:0] OFS_GOP = 5'h10;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ****************************************************************
  // Channel control fields
  // ****************************************************************
  localparam int CTL_DE = 0;
  localparam int CTL_TE = 1;
  localparam int CTL_IE = 2;
  localparam int CTL_TS_LO = 3;
  localparam int CTL_TM = 5;
  localparam int CTL_DS = 6;
  localparam int CTL_RS_LO = 8;
  localparam int CTL_SM_LO = 12;
  localparam int CTL_DM_LO = 14;
  localparam int CTL_AL = 16;
  localparam int CTL_AM = 17;
  localparam int CTL_RL = 18;
  localparam logic [31:0] CTL_MASK = 32'h0007_ff7f;

  // ****************************************************************
  // Global operation fields and count width
  // ****************************************************************
  localparam int GOP_DME = 0;
  localparam int GOP_PR_LO = 8;
  localparam logic [15:0] GOP_MASK = 16'h0301;
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_ONE = 24'h00_0001;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [3:0] RS_EXT = 4'h0;
  localparam logic [3:0] RS_AUTO = 4'h4;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int WR_STROBE_NS = 16;
  localparam int WR_STROBE_CYC =
    (WR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_STEP = 2'b11
  } ddc_state_t;

  // Unit size in bytes
  function automatic logic [31:0] ddc_unit_bytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: ddc_unit_bytes = 32'h0000_0001; // see [R23]
      SZ_WORD: ddc_unit_bytes = 32'h0000_0002;
      default: ddc_unit_bytes = 32'h0000_0004;
    endcase
  endfunction

  // Next address for a fixed, up or down mode
  function automatic logic [31:0] ddc_step_addr(input logic [31:0] a,
      input logic [1:0] mode, input logic [1:0] sz);
    case (mode)
      AM_INC: ddc_step_addr = a + ddc_unit_bytes(sz);
      AM_DEC: ddc_step_addr = a - ddc_unit_bytes(sz);
      default: ddc_step_addr = a;
    endcase
  endfunction

  // Byte-enable merge of a register write
  function automatic logic [31:0] ddc_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      ddc_merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

endpackage
`default_nettype wire

// *** rtl/ddc_channel.sv ***
// Overview of operation
// [R01] Source address fixed, up or down
// [R02] Destination address fixed, up or down
// [R03] Count uses low 24 bits only
// [R04] Count zero means 16,777,216 transfers
// [R05] Count decrements once per transfer
// [R06] Auto-request starts when run bit set
// [R07] Software programs everything before run bit
// [R08] Read source, write external, step, repeat
// [R09] Master enable gates all channel activity
// [R10] Global bits 9:8 hold channel order
// [R11] Control bits 15:14 destination step mode
// [R12] Control bits 13:12 source step mode
// [R13] Bits 11:8 choose request source
// [R14] Bit 5 selects burst bus mode
// [R15] Bits 4:3 choose transfer unit size
// [R16] Bit 2 enables end-of-count interrupt
// [R17] Hardware sets done flag at end
// [R18] Bit 6 chooses request pin sensing
// [R19] Bit 16 sets acknowledge polarity
// [R20] Bit 17 chooses acknowledge cycle
// [R21] Bit 18 sets accepted-output polarity
// [R22] Activation by pin, peripherals or auto
// [R23] Step size 1, 2 or 4 bytes
//
// Our own choices: register access over Avalon-MM and the address map.
`default_nettype none
module ddc_channel
  import ddc_pkg::*;
#(
  parameter int WR_CYC = WR_STROBE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic src_rd_req,
  output logic [31:0] src_rd_addr,
  output logic [1:0] src_rd_size,
  input wire logic [31:0] src_rd_data,
  input wire logic src_rd_valid,
  output logic [31:0] ext_addr,
  output logic [31:0] ext_data,
  output logic sram_chip_select_n,
  output logic write_strobe_upper_n,
  output logic write_strobe_lower_n,
  input wire logic xfer_req_pin,
  input wire logic [15:0] periph_req,
  output logic xfer_ack_pin,
  output logic req_accept_pin,
  output logic bus_hold,
  output logic [1:0] chan_order,
  output logic irq
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [31:0] dma_source_address;
  logic [31:0] dma_destination_address;
  logic [CNT_W-1:0] dma_transfer_count;
  logic [31:0] dma_channel_control;
  logic [15:0] dma_global_operation;
  ddc_state_t state;
  ddc_state_t next_state;
  logic [3:0] wr_cnt;
  logic req_pin_last;

  // ****************************************************************
  // Control field decode
  // ****************************************************************
  wire logic chan_run_bit = dma_channel_control[CTL_DE];
  wire logic count_done_flag = dma_channel_control[CTL_TE];
  wire logic count_done_irq_on = dma_channel_control[CTL_IE];
  wire logic [1:0] unit_size = dma_channel_control[CTL_TS_LO +: 2];
  wire logic burst_select = dma_channel_control[CTL_TM];
  wire logic req_pin_sense = dma_channel_control[CTL_DS];
  wire logic [3:0] request_source_sel = dma_channel_control[CTL_RS_LO +: 4];
  wire logic [1:0] src_step = dma_channel_control[CTL_SM_LO +: 2];
  wire logic [1:0] dst_step = dma_channel_control[CTL_DM_LO +: 2];
  wire logic ack_polarity = dma_channel_control[CTL_AL];
  wire logic ack_phase_sel = dma_channel_control[CTL_AM];
  wire logic req_check_polarity = dma_channel_control[CTL_RL];
  wire logic master_on_bit = dma_global_operation[GOP_DME];

  // ****************************************************************
  // Bus slave decode
  // ****************************************************************
  // Access is answered one cycle after it is seen
  wire logic bus_req = avs_read | avs_write;
  wire logic bus_take = bus_req & ~avs_waitrequest;
  wire logic wr_take = avs_write & ~avs_waitrequest;
  wire logic [4:0] reg_ofs = {avs_address[4:2], 2'b00};
  wire logic wr_src = wr_take & (reg_ofs == OFS_SRC);
  wire logic wr_dst = wr_take & (reg_ofs == OFS_DST);
  wire logic wr_cnt_reg = wr_take & (reg_ofs == OFS_CNT);
  wire logic wr_ctrl = wr_take & (reg_ofs == OFS_CTRL);
  wire logic wr_gop = wr_take & (reg_ofs == OFS_GOP);
  wire logic [31:0] cnt_word = {8'h00, dma_transfer_count}; // see [R03]

  // Read data select; unmapped offsets read zero
  wire logic [31:0] rd_mux =
    (reg_ofs == OFS_SRC) ? dma_source_address :
    (reg_ofs == OFS_DST) ? dma_destination_address :
    (reg_ofs == OFS_CNT) ? cnt_word :
    (reg_ofs == OFS_CTRL) ? dma_channel_control :
    (reg_ofs == OFS_GOP) ? {16'h0000, dma_global_operation} :
    32'h0000_0000;

  // ****************************************************************
  // Request sources
  // ****************************************************************
  // Low level or falling edge on the request pin
  wire logic pin_req = req_pin_sense ?
    (req_pin_last & ~xfer_req_pin) : ~xfer_req_pin; // see [R18]
  wire logic src_is_ext = (request_source_sel == RS_EXT);
  wire logic src_is_auto = (request_source_sel == RS_AUTO);
  wire logic xfer_req = src_is_auto ? 1'b1 :          // see [R13]
    src_is_ext ? pin_req :                            // see [R22]
    periph_req[request_source_sel];
  wire logic run_ok = chan_run_bit & master_on_bit &
                      ~count_done_flag; // see [R09]
  wire logic start = (state == ST_IDLE) & run_ok & xfer_req; // see [R06]
  wire logic last_unit = (dma_transfer_count == CNT_ONE);
  wire logic in_step = (state == ST_STEP);
  wire logic step_go = in_step & ~last_unit & burst_select &
                       run_ok; // see [R14]

  // ****************************************************************
  // Next-value logic for channel registers
  // ****************************************************************
  wire logic [31:0] next_src = in_step ?
    ddc_step_addr(dma_source_address, src_step, unit_size) : // see [R12]
    wr_src ? ddc_merge(dma_source_address, avs_writedata, avs_byteenable) :
    dma_source_address; // see [R01]
  wire logic [31:0] next_dst = in_step ?
    ddc_step_addr(dma_destination_address, dst_step, unit_size) : // see [R11]
    wr_dst ? ddc_merge(dma_destination_address, avs_writedata,
                       avs_byteenable) :
    dma_destination_address; // see [R02]
  wire logic [31:0] cnt_merged = ddc_merge(cnt_word, avs_writedata,
                                           avs_byteenable);
  // Zero wraps to all ones, giving the full 2^24 run
  wire logic [CNT_W-1:0] next_count = in_step ?
    dma_transfer_count - CNT_ONE :                  // see [R05] see [R04]
    wr_cnt_reg ? cnt_merged[CNT_W-1:0] : dma_transfer_count; // see [R03]
  wire logic [31:0] ctrl_merged = ddc_merge(dma_channel_control,
                                            avs_writedata, avs_byteenable);
  // Done flag: hardware set beats a software clear
  wire logic te_set = in_step & last_unit; // see [R17]
  wire logic te_clr = wr_ctrl & avs_byteenable[0] & ~avs_writedata[CTL_TE];
  wire logic next_te = te_set | (count_done_flag & ~te_clr);
  wire logic [31:0] ctrl_sw = wr_ctrl ? (ctrl_merged & CTL_MASK) :
                                       dma_channel_control;
  wire logic [31:0] next_ctrl = {ctrl_sw[31:CTL_TE+1], next_te,
                                 ctrl_sw[CTL_DE]};
  wire logic [31:0] gop_merged = ddc_merge({16'h0000, dma_global_operation},
                                           avs_writedata, avs_byteenable);
  wire logic [15:0] next_gop = wr_gop ? (gop_merged[15:0] & GOP_MASK) :
                                        dma_global_operation; // see [R10]

  // ****************************************************************
  // Channel sequencer
  // ****************************************************************
  // Read source, write external, step addresses, repeat
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_READ; // see [R08]
        end
      end
      ST_READ: begin
        if (src_rd_valid) begin
          next_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (wr_cnt == 4'h0) begin
          next_state = ST_STEP;
        end
      end
      ST_STEP: begin
        next_state = step_go ? ST_READ : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Phase decode for the registered pin outputs
  wire logic issue_rd = start | step_go;
  wire logic enter_wr = (state == ST_READ) & src_rd_valid;
  wire logic leave_wr = (state == ST_WRITE) & (wr_cnt == 4'h0);
  wire logic next_strobe = enter_wr | ((state == ST_WRITE) & ~leave_wr);
  wire logic ack_active = ack_phase_sel ?
    (next_state == ST_WRITE) : (next_state == ST_READ); // see [R20]
  wire logic accept_now = start & src_is_ext;
  // Byte units take one lane, wider units both
  wire logic lane_upper = (unit_size != SZ_BYTE) | ~dma_destination_address[0];
  wire logic lane_lower = (unit_size != SZ_BYTE) | dma_destination_address[0];
  wire logic next_irq = count_done_irq_on & next_te &
                        next_ctrl[CTL_IE]; // see [R16]

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Bus slave handshake and read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= REG_RESET;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      avs_readdata <= rd_mux;
    end
  end

  // Software-visible registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_source_address <= REG_RESET;
      dma_destination_address <= REG_RESET;
      dma_transfer_count <= REG_RESET[CNT_W-1:0];
      dma_channel_control <= REG_RESET;
      dma_global_operation <= REG_RESET[15:0];
    end else begin
      dma_source_address <= next_src;
      dma_destination_address <= next_dst;
      dma_transfer_count <= next_count;
      dma_channel_control <= next_ctrl;
      dma_global_operation <= next_gop;
    end
  end

  // Sequencer state, strobe timer and request pin sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      wr_cnt <= 4'h0;
      req_pin_last <= 1'b1;
    end else begin
      state <= next_state;
      wr_cnt <= enter_wr ? 4'(WR_CYC - 1) :
                (wr_cnt != 4'h0) ? wr_cnt - 4'h1 : wr_cnt;
      req_pin_last <= xfer_req_pin;
    end
  end

  // Internal source read port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_rd_req <= 1'b0;
      src_rd_addr <= REG_RESET;
      src_rd_size <= SZ_BYTE;
    end else begin
      src_rd_req <= issue_rd | (src_rd_req & ~src_rd_valid);
      src_rd_addr <= issue_rd ? next_src : src_rd_addr; // see [R08]
      src_rd_size <= issue_rd ? unit_size : src_rd_size; // see [R15]
    end
  end

  // External write bus, strobes active low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_addr <= REG_RESET;
      ext_data <= REG_RESET;
      sram_chip_select_n <= 1'b1;
      write_strobe_upper_n <= 1'b1;
      write_strobe_lower_n <= 1'b1;
    end else begin
      ext_addr <= enter_wr ? dma_destination_address : ext_addr;
      ext_data <= enter_wr ? src_rd_data : ext_data;
      sram_chip_select_n <= ~next_strobe; // see [R08]
      write_strobe_upper_n <= ~(next_strobe & lane_upper);
      write_strobe_lower_n <= ~(next_strobe & lane_lower);
    end
  end

  // Handshake pins, bus ownership and interrupt
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_ack_pin <= 1'b0;
      req_accept_pin <= 1'b0;
      bus_hold <= 1'b0;
      chan_order <= 2'b00;
      irq <= 1'b0;
    end else begin
      xfer_ack_pin <= ack_active ^ next_ctrl[CTL_AL]; // see [R19]
      req_accept_pin <= accept_now ^ next_ctrl[CTL_RL]; // see [R21]
      bus_hold <= (next_state != ST_IDLE);
      chan_order <= next_gop[GOP_PR_LO +: 2]; // see [R10]
      irq <= next_irq;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_unit_read;
    (state == ST_READ) && src_rd_valid;
  endsequence

  sequence s_strobe_pulse;
    !sram_chip_select_n [*2] ##1 sram_chip_select_n;
  endsequence

  a_bus_one_wait: assert property ( // our own choice: Avalon-MM register access
    bus_req && avs_waitrequest && !$past(bus_take) |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");

  a_cnt_upper_zero: assert property ( // see [R03]
    !avs_waitrequest && avs_read && reg_ofs == OFS_CNT
    |-> avs_readdata[31:24] == 8'h00)
    else $error("count upper byte not zero");

  a_src_inc_long: assert property ( // see [R12]
    in_step && src_step == AM_INC && unit_size == 2'h2
    |=> dma_source_address == $past(dma_source_address) + 32'h4)
    else $error("source did not step by four");

  a_dst_dec_word: assert property ( // see [R23]
    in_step && dst_step == AM_DEC && unit_size == SZ_WORD
    |=> dma_destination_address == $past(dma_destination_address) - 32'h2)
    else $error("destination did not step down by two");

  a_count_dec: assert property ( // see [R05]
    in_step |=> dma_transfer_count == $past(dma_transfer_count) - CNT_ONE)
    else $error("count not decremented");

  a_zero_count_max: assert property ( // see [R04]
    in_step && dma_transfer_count == 24'h000000
    |=> !count_done_flag && dma_transfer_count == 24'hffffff)
    else $error("zero count ended the run");

  a_done_flag: assert property ( // see [R17]
    in_step && last_unit |=> count_done_flag && state == ST_IDLE)
    else $error("done flag not set at end");

  a_auto_start: assert property ( // see [R06]
    state == ST_IDLE && src_is_auto && run_ok |=> state == ST_READ ##0
    src_rd_req)
    else $error("auto request did not start");

  a_master_gate: assert property ( // see [R09]
    state == ST_IDLE && !master_on_bit |=> state == ST_IDLE)
    else $error("channel ran with master enable off");

  a_write_strobe: assert property ( // see [R08]
    s_unit_read |=> s_strobe_pulse)
    else $error("external write strobe wrong width");

  a_irq_follows: assert property ( // see [R16]
    irq |-> count_done_flag && dma_channel_control[CTL_IE])
    else $error("interrupt without enabled done flag");

  a_accept_once: assert property ( // see [R21]
    req_accept_pin != req_check_polarity
    |=> req_accept_pin == req_check_polarity)
    else $error("accept pulse longer than one cycle");

  a_hold_idle: assert property ( // see [R14]
    state == ST_IDLE && !start |=> !bus_hold)
    else $error("bus held while idle");

endmodule
`default_nettype wire

// *** bench/ddc_src_mem.sv ***
`default_nettype none
module ddc_src_mem (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic src_rd_req,
  input wire logic [31:0] src_rd_addr,
  output logic [31:0] src_rd_data,
  output logic src_rd_valid,
  input wire logic sram_chip_select_n,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_data,
  output int wn,
  output logic [31:0] wa [8],
  output logic [31:0] wd [8]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic cs_q;
  // **************************************************
  // Source memory: answers after lat cycles
  // **************************************************
  // Data is the inverted address; idle data toggles every cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      src_rd_valid <= 1'h0;
      src_rd_data <= 32'h0;
    end else if (src_rd_valid) begin
      src_rd_valid <= 1'h0;
      cnt <= 4'h0;
      src_rd_data <= ~src_rd_data;
    end else if (src_rd_req && cnt == lat) begin
      src_rd_valid <= 1'h1;
      src_rd_data <= ~src_rd_addr;
    end else begin
      cnt <= src_rd_req ? cnt + 4'h1 : cnt;
      src_rd_data <= ~src_rd_data;
    end
  end
  // **************************************************
  // External memory: records each written unit
  // **************************************************
  // Address and data are taken as chip select falls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= 1'h1;
      wn <= 0;
    end else begin
      cs_q <= sram_chip_select_n;
      if (!sram_chip_select_n && cs_q) begin
        wa[wn[2:0]] <= ext_addr;
        wd[wn[2:0]] <= ext_data;
        wn <= wn + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/dual_address_dma_channel_tb.sv ***
`default_nettype none
module dual_address_dma_channel_tb;
  import ddc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, rd, wr, wq, sv, cs_n, wu_n, wl_n, sq, ack, acc;
  logic hold, irq, pin;
  logic [4:0] adr;
  logic [31:0] wdat, rdat, sa, sd, ea, ed, q;
  logic [1:0] ssz, ord;
  logic [15:0] preq;
  logic [3:0] lat;
  logic [31:0] wa [8];
  logic [31:0] wd [8];
  int errors, n_tests, cyc, wn, b, nu, nl, na, nk, nh;
  ddc_channel uut (.clk(clk), .reset_n(reset_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wq),
    .src_rd_req(sq), .src_rd_addr(sa), .src_rd_size(ssz),
    .src_rd_data(sd), .src_rd_valid(sv), .ext_addr(ea), .ext_data(ed),
    .sram_chip_select_n(cs_n), .write_strobe_upper_n(wu_n),
    .write_strobe_lower_n(wl_n), .xfer_req_pin(pin), .periph_req(preq),
    .xfer_ack_pin(ack), .req_accept_pin(acc), .bus_hold(hold),
    .chan_order(ord), .irq(irq));
  ddc_src_mem mem (.clk(clk), .reset_n(reset_n), .lat(lat),
    .src_rd_req(sq), .src_rd_addr(sa), .src_rd_data(sd),
    .src_rd_valid(sv), .sram_chip_select_n(cs_n), .ext_addr(ea),
    .ext_data(ed), .wn(wn), .wa(wa), .wd(wd));
  // **************************************************
  // Clock, reset and cycle limit
  // **************************************************
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Low cycles of strobes and pins, high cycles of bus hold
  always @(posedge clk) begin
    cyc++;
    nu += int'(!wu_n);
    nl += int'(!wl_n);
    na += int'(!acc);
    nk += int'(!ack);
    nh += int'(hold);
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  // **************************************************
  // Bus access, comparison and closing
  // **************************************************
  // One Avalon access held until waitrequest is seen low
  task automatic acc_bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= ~w;
    wr <= w;
    do @(posedge clk); while (wq !== 1'h0);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic rchk(input string nm, input logic [4:0] a,
      input logic [31:0] e);
    acc_bus(1'h0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // Polls the done flag a bounded number of times
  task automatic wait_done();
    q = 32'h0;
    for (int i = 0; i < 60 && q[CTL_TE] !== 1'h1; i++) begin
      acc_bus(1'h0, OFS_CTRL, 32'h0);
    end
    chk("done flag", 32'h1, {31'h0, q[CTL_TE]});
  endtask
  task automatic prog(input logic [31:0] s, d, n);
    acc_bus(1'h1, OFS_SRC, s);
    acc_bus(1'h1, OFS_DST, d);
    acc_bus(1'h1, OFS_CNT, n);
    b = wn;
  endtask
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // **************************************************
  // Scenarios
  // **************************************************
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rchk("reset value", 5'(4 * i), 32'h0);
    end
    acc_bus(1'h1, OFS_CNT, 32'hffff_ffff);
    rchk("count upper", OFS_CNT, 32'h00ff_ffff);
    acc_bus(1'h1, OFS_CTRL, 32'hffff_ffff);
    rchk("control bits", OFS_CTRL, CTL_MASK & 32'hffff_fffd);
    acc_bus(1'h1, OFS_CTRL, 32'h0);
    acc_bus(1'h1, 5'h14, 32'hffff_ffff);
    rchk("unmapped", 5'h14, 32'h0);
    acc_bus(1'h1, OFS_GOP, 32'h0000_ffff);
    rchk("global bits", OFS_GOP, 32'h0000_0301);
    chk("chan order", 32'h3, {30'h0, ord});
    acc_bus(1'h1, OFS_GOP, 32'h0);
    $display("test regs done");
  endtask
  // Longword burst, both up, slow source, irq on
  task automatic t_burst();
    lat <= 4'h3;
    prog(32'hffff_e000, 32'h0040_0000, 32'h2);
    acc_bus(1'h1, OFS_CTRL, 32'h0000_5435);
    repeat (20) @(posedge clk);
    chk("gated writes", 32'(b), 32'(wn));
    acc_bus(1'h1, OFS_GOP, 32'h1);
    wait_done();
    chk("units", 32'(b + 2), 32'(wn));
    for (int i = 0; i < 2; i++) begin
      chk("ext addr", 32'h0040_0000 + 4 * i, wa[b + i]);
      chk("ext data", ~(32'hffff_e000 + 4 * i), wd[b + i]);
    end
    rchk("src end", OFS_SRC, 32'hffff_e008);
    rchk("dst end", OFS_DST, 32'h0040_0008);
    rchk("count end", OFS_CNT, 32'h0);
    chk("irq", 32'h1, {31'h0, irq});
    $display("test burst done");
  endtask
  // Byte units, fixed source, destination down, prompt source
  task automatic t_byte();
    int u, l;
    lat <= 4'h0;
    acc_bus(1'h1, OFS_CTRL, 32'h0);
    prog(32'h0000_0100, 32'h0000_0203, 32'h3);
    chk("irq clear", 32'h0, {31'h0, irq});
    u = nu;
    l = nl;
    acc_bus(1'h1, OFS_CTRL, 32'h0000_8401);
    wait_done();
    chk("units", 32'(b + 3), 32'(wn));
    chk("upper lane", 32'(WR_STROBE_CYC), 32'(nu - u));
    chk("lower lane", 32'(2 * WR_STROBE_CYC), 32'(nl - l));
    for (int i = 0; i < 3; i++) begin
      chk("ext addr", 32'h0000_0203 - i, wa[b + i]);
      chk("ext data", ~32'h0000_0100, wd[b + i]);
    end
    rchk("src end", OFS_SRC, 32'h0000_0100);
    rchk("dst end", OFS_DST, 32'h0000_0200);
    $display("test byte done");
  endtask
  // Count zero, word units down, one unit from source 0101
  task automatic t_periph();
    acc_bus(1'h1, OFS_CTRL, 32'h0);
    prog(32'h0000_0400, 32'h0000_0800, 32'h0);
    acc_bus(1'h1, OFS_CTRL, 32'h0000_8509);
    repeat (20) @(posedge clk);
    chk("no request", 32'(b), 32'(wn));
    preq <= 16'h0020;
    for (int i = 0; i < 50 && wn == b; i++) @(posedge clk);
    preq <= 16'h0;
    repeat (8) @(posedge clk);
    chk("periph unit", 32'h0000_0800, wa[b]);
    chk("units", 32'(b + 1), 32'(wn));
    rchk("zero count", OFS_CNT, 32'h00ff_ffff);
    rchk("still running", OFS_CTRL, 32'h0000_8509);
    rchk("dst down", OFS_DST, 32'h0000_07fe);
    $display("test periph done");
  endtask
  // Pin falling edge, active-low accept and write-phase acknowledge
  task automatic t_pin();
    int c0, c1, c2, c3, c4;
    acc_bus(1'h1, OFS_CTRL, 32'h0);
    prog(32'h0000_0500, 32'h0000_0c00, 32'h1);
    acc_bus(1'h1, OFS_CTRL, 32'h0007_5049);
    repeat (4) @(posedge clk);
    c0 = na;
    c1 = nk;
    c2 = nu;
    c3 = nl;
    c4 = nh;
    chk("no pin edge", 32'(b), 32'(wn));
    chk("ack idle", 32'h1, {31'h0, ack});
    pin <= 1'h0;
    wait_done();
    pin <= 1'h1;
    chk("accept pulse", 32'h1, 32'(na - c0));
    chk("ack cycles", 32'(WR_STROBE_CYC), 32'(nk - c1));
    chk("upper lane", 32'(WR_STROBE_CYC), 32'(nu - c2));
    chk("lower lane", 32'(WR_STROBE_CYC), 32'(nl - c3));
    chk("bus held", 32'h1, 32'(nh > c4));
    chk("bus free", 32'h0, {31'h0, hold});
    chk("unit size", 32'(SZ_WORD), {30'h0, ssz});
    chk("pin unit", ~32'h0000_0500, wd[b]);
    $display("test pin done");
  endtask
  // **************************************************
  // Main sequence
  // **************************************************
  initial begin
    reset_n = 1'h0;
    rd = 1'h0;
    wr = 1'h0;
    adr = 5'h0;
    wdat = 32'h0;
    preq = 16'h0;
    pin = 1'h1;
    lat = 4'h0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    t_regs();
    t_burst();
    t_byte();
    t_periph();
    t_pin();
    conclude();
  end
endmodule
`default_nettype wire
